// ### logic/spfc_top.sv
// APB register front end and row erase and program sequencer
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "spfc_params.svh"
module spfc_top
   import spfc_pkg::*;
#(
   parameter int unsigned OP_CYCLES =
      `SPFC_OP_TIME_NS / `SPFC_CLK_PERIOD_NS,
   parameter int ROW_WORDS = `SPFC_ROW_WORDS,
   parameter int ROWS = `SPFC_PANEL_ROWS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cpu_stall
);
   localparam int LW = $clog2(ROW_WORDS);
   localparam int AW = $clog2(ROW_WORDS * ROWS);

   // Parameter check
   if (OP_CYCLES < 1 || ROW_WORDS != 32 || AW > 15)
      begin : bad_param
      $error("spfc_top: unsupported parameter values");
   end

   spfc_arr_if #(.AW(AW), .LW(LW)) arr_if ();

   spfc_array #(.ROW_WORDS(ROW_WORDS), .ROWS(ROWS)) u_array (
      .pclk(pclk),
      .port(arr_if.arr)
   );

   logic [15:0] ctrl_reg;
   logic [15:0] addr_lo_reg;
   logic [7:0] addr_hi_reg;
   logic [7:0] table_page_register_reg;
   logic [15:0] ea_reg;
   logic ack_reg;
   logic [31:0] prdata_reg;
   spfc_key_t key_reg;
   spfc_state_t state_reg;
   logic [31:0] cnt_reg;
   logic [LW-1:0] idx_reg;

   // Address decode
   wire sel_ctrl = spfc_hit(paddr, `SPFC_OFF_CTRL);
   wire sel_alo = spfc_hit(paddr, `SPFC_OFF_ADDR_LO);
   wire sel_ahi = spfc_hit(paddr, `SPFC_OFF_ADDR_HI);
   wire sel_key = spfc_hit(paddr, `SPFC_OFF_KEY);
   wire sel_pag = spfc_hit(paddr, `SPFC_OFF_TABLE_PAGE_REGISTER);
   wire sel_ea = spfc_hit(paddr, `SPFC_OFF_TBL_EA);
   wire sel_tlo = spfc_hit(paddr, `SPFC_OFF_TBL_LOW);
   wire sel_thi = spfc_hit(paddr, `SPFC_OFF_TBL_HIGH);
   wire sel_tbl = sel_tlo | sel_thi;
   wire mapped = sel_ctrl | sel_alo | sel_ahi | sel_key | sel_pag |
      sel_ea | sel_tbl;

   // Handshake: one wait state per access, no answer at all while busy
   wire busy = state_reg != SPFC_IDLE;
   wire access = psel & penable;
   wire ack_next = access & ~ack_reg & ~busy;
   wire wr_fire = pready & pwrite;
   wire tbl_fire = pready & sel_tbl;
   assign pready = access & ack_reg;
   assign pslverr = pready & ~mapped;
   assign prdata = prdata_reg;
   assign cpu_stall = ctrl_reg[`SPFC_CTRL_START_BIT];

   // Table address from page byte and 16-bit address
   wire [23:0] tbl_addr = {table_page_register_reg, ea_reg};
   assign arr_if.rd_addr = tbl_addr[AW:1];

   // Latch loads: low word lanes or the high byte lane
   assign arr_if.lat_we = wr_fire & sel_tbl;
   assign arr_if.lat_idx = ea_reg[LW:1];
   assign arr_if.lat_wdata = {pwdata[7:0], pwdata[15:0]};
   assign arr_if.lat_be = sel_tlo ? {1'b0, pstrb[1:0]} :
      {pstrb[0], 2'b00};

   // Row commit addressing from the low address register
   assign arr_if.com_we = state_reg == SPFC_COMMIT;
   assign arr_if.com_erase = ctrl_reg[`SPFC_CTRL_ERASE_BIT];
   assign arr_if.com_addr = {addr_lo_reg[AW:LW+1], idx_reg};

   // Read data selection
   wire [31:0] rdata_mux =
      sel_ctrl ? {16'h0000, ctrl_reg} :
      sel_alo ? {16'h0000, addr_lo_reg} :
      sel_ahi ? {24'h000000, addr_hi_reg} :
      sel_pag ? {24'h000000, table_page_register_reg} :
      sel_ea ? {16'h0000, ea_reg} :
      sel_tlo ? {16'h0000, arr_if.rd_data[15:0]} :
      sel_thi ? {24'h000000, arr_if.rd_data[23:16]} :
      32'h00000000; // Key register reads as zero

   // Start request decode on the written control value
   wire [3:0] w_optype = pwdata[`SPFC_CTRL_OPTYPE_LSB +: 4];
   wire [3:0] w_memsel = pwdata[`SPFC_CTRL_MEMSEL_LSB +: 4];
   wire launch = wr_fire & sel_ctrl & pwdata[`SPFC_CTRL_START_BIT] &
      (key_reg == SPFC_KEY_ARMED) & pwdata[`SPFC_CTRL_PROGRAM_ENABLE_BIT_BIT] &
      (w_optype == `SPFC_OPTYPE_ROW) &
      (w_memsel == `SPFC_MEMSEL_PFLASH);
   wire wait_done = cnt_reg == 32'(OP_CYCLES - 1);
   wire row_done = idx_reg == LW'(ROW_WORDS - 1);

   // Unlock tracking: any write other than the expected key disarms
   spfc_key_t key_next;
   always_comb begin
      key_next = key_reg;
      if (wr_fire) begin
         if (sel_key && pwdata[7:0] == `SPFC_KEY_FIRST) begin
            key_next = SPFC_KEY_HALF;
         end else if (sel_key && pwdata[7:0] == `SPFC_KEY_SECOND &&
               key_reg == SPFC_KEY_HALF) begin
            key_next = SPFC_KEY_ARMED;
         end else begin
            key_next = SPFC_KEY_NONE;
         end
      end
   end

   // Bus handshake and read data flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         key_reg <= SPFC_KEY_NONE;
      end else begin
         ack_reg <= ack_next;
         key_reg <= key_next;
         if (ack_next) begin
            prdata_reg <= rdata_mux;
         end
      end
   end

   // Table pointer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_page_register_reg <= `SPFC_TABLE_PAGE_REGISTER_RESET;
         ea_reg <= `SPFC_TBL_EA_RESET;
      end else if (wr_fire && sel_pag) begin
         table_page_register_reg <= pwdata[7:0];
      end else if (wr_fire && sel_ea) begin
         ea_reg <= pwdata[15:0];
      end
   end

   // Flash address: captured by table accesses or written directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_lo_reg <= `SPFC_ADDR_LO_RESET;
         addr_hi_reg <= `SPFC_ADDR_HI_RESET;
      end else if (tbl_fire) begin
         addr_lo_reg <= tbl_addr[15:0];
         addr_hi_reg <= tbl_addr[23:16];
      end else if (wr_fire && sel_alo) begin
         addr_lo_reg <= pwdata[15:0];
      end else if (wr_fire && sel_ahi) begin
         addr_hi_reg <= pwdata[7:0];
      end
   end

   // Control register: fields by write, start by unlock, cleared at end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `SPFC_CTRL_RESET;
      end else if (state_reg == SPFC_COMMIT && row_done) begin
         ctrl_reg[`SPFC_CTRL_START_BIT] <= 1'b0;
      end else if (wr_fire && sel_ctrl) begin
         ctrl_reg <= {launch, pwdata[14:0]};
      end
   end

   // Sequencer: wait the operation time, then commit the row
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SPFC_IDLE;
         cnt_reg <= 32'h00000000;
         idx_reg <= '0;
      end else begin
         case (state_reg)
            SPFC_IDLE: begin
               cnt_reg <= 32'h00000000;
               idx_reg <= '0;
               if (launch) begin
                  state_reg <= SPFC_WAIT;
               end
            end
            SPFC_WAIT: begin
               cnt_reg <= cnt_reg + 32'h00000001;
               if (wait_done) begin
                  state_reg <= SPFC_COMMIT;
               end
            end
            SPFC_COMMIT: begin
               idx_reg <= idx_reg + LW'(1);
               if (row_done) begin
                  state_reg <= SPFC_IDLE;
               end
            end
            default: begin
               state_reg <= SPFC_IDLE;
            end
         endcase
      end
   end

   // Stall length helper: counts cycles while the start bit stands
   logic [31:0] stall_len_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_len_reg <= 32'h00000000;
      end else if (cpu_stall) begin
         stall_len_reg <= stall_len_reg + 32'h00000001;
      end else begin
         stall_len_reg <= 32'h00000000;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   stall_busy_a: assert property (
      cpu_stall == busy) else $error("stall differs from busy");
   wait_len_a: assert property (
      state_reg == SPFC_WAIT && state_reg != $past(state_reg)
      |-> cnt_reg == 32'h00000000) else $error("wait count not zero");
   commit_entry_a: assert property (
      $rose(arr_if.com_we) |-> $past(wait_done) && idx_reg == '0)
      else $error("commit began early");
   commit_end_a: assert property (
      arr_if.com_we && row_done |=> !arr_if.com_we && !cpu_stall)
      else $error("commit did not end after row");
   start_clear_a: assert property (
      $fell(cpu_stall) |-> $past(state_reg) == SPFC_COMMIT)
      else $error("start bit cleared outside commit");
   key_gate_a: assert property (
      $rose(cpu_stall) |-> $past(key_reg) == SPFC_KEY_ARMED
      && $past(wr_fire) && $past(sel_ctrl)) else $error("start without keys");
   latch_only_a: assert property (
      arr_if.lat_we |-> !arr_if.com_we && $past(access) && access)
      else $error("latch write not two cycles");
   addr_capture_a: assert property (
      tbl_fire |=> addr_lo_reg == $past(ea_reg)
      && addr_hi_reg == $past(table_page_register_reg)) else $error("address not captured");
   busy_hold_a: assert property (
      busy |-> !pready) else $error("bus answered while busy");
   // Whole stall spans the wait plus one commit per row word
   stall_len_a: assert property (
      $fell(cpu_stall) |-> stall_len_reg == 32'(OP_CYCLES + ROW_WORDS))
      else $error("stall length differs from wait plus row");

   // Bus answer shape: one cycle, error only with an answer
   ready_pulse_a: assert property (
      pready |=> !pready) else $error("ready held over two cycles");
   slverr_qual_a: assert property (
      pslverr |-> pready && !mapped) else $error("error without answer");
   key_read_a: assert property (
      pready && !pwrite && sel_key |-> prdata == 32'h00000000)
      else $error("key register read back");

   // Unlock is consumed by a start and needs program enable
   arm_clear_a: assert property (
      launch |=> key_reg == SPFC_KEY_NONE) else $error("keys still armed");
   start_program_enable_bit_a: assert property (
      $rose(cpu_stall) |-> ctrl_reg[`SPFC_CTRL_PROGRAM_ENABLE_BIT_BIT])
      else $error("start without program enable");

   // Latch lanes and row addressing of the commit
   high_lane_a: assert property (
      arr_if.lat_we && sel_thi |-> arr_if.lat_be[1:0] == 2'b00)
      else $error("high part touched low lanes");
   commit_row_a: assert property (
      arr_if.com_we |-> arr_if.com_addr[AW-1:LW] == addr_lo_reg[AW:LW+1])
      else $error("commit left the selected row");
   idle_quiet_a: assert property (
      state_reg == SPFC_IDLE |-> !arr_if.com_we && idx_reg == '0)
      else $error("row index not back at word zero");

   erase_op_c: cover property ($fell(cpu_stall) && arr_if.com_erase);
   program_op_c: cover property ($fell(cpu_stall) && !arr_if.com_erase);
   key_refused_c: cover property (wr_fire && sel_ctrl
      && pwdata[`SPFC_CTRL_START_BIT] && !launch);
   unmapped_c: cover property (pslverr);
   latch_load_c: cover property (arr_if.lat_we && sel_thi);
endmodule : spfc_top
`default_nettype wire

// ### logic/spfc_params.svh
// Constants of the self-programming flash controller: offsets, fields, times
`ifndef SPFC_PARAMS_SVH
`define SPFC_PARAMS_SVH

// Register byte offsets on the APB slave
`define SPFC_OFF_CTRL 8'h00
`define SPFC_OFF_ADDR_LO 8'h04
`define SPFC_OFF_ADDR_HI 8'h08
`define SPFC_OFF_KEY 8'h0c
`define SPFC_OFF_TABLE_PAGE_REGISTER 8'h10
`define SPFC_OFF_TBL_EA 8'h14
`define SPFC_OFF_TBL_LOW 8'h18
`define SPFC_OFF_TBL_HIGH 8'h1c

// Control register fields
`define SPFC_CTRL_START_BIT 15
`define SPFC_CTRL_PROGRAM_ENABLE_BIT_BIT 14
`define SPFC_CTRL_ERASE_BIT 6
`define SPFC_CTRL_MEMSEL_LSB 8
`define SPFC_CTRL_OPTYPE_LSB 0
`define SPFC_OPTYPE_ROW 4'h1
`define SPFC_MEMSEL_PFLASH 4'h0

// Reset values
`define SPFC_CTRL_RESET 16'h0000
`define SPFC_ADDR_LO_RESET 16'h0000
`define SPFC_ADDR_HI_RESET 8'h00
`define SPFC_TABLE_PAGE_REGISTER_RESET 8'h00
`define SPFC_TBL_EA_RESET 16'h0000

// Unlock keys and array shape
`define SPFC_KEY_FIRST 8'h55
`define SPFC_KEY_SECOND 8'haa
`define SPFC_ROW_WORDS 32
`define SPFC_PANEL_ROWS 128
`define SPFC_ERASED_WORD 24'hffffff

// Operation time and clock period
`define SPFC_OP_TIME_NS 2000000
`define SPFC_CLK_PERIOD_NS 4

`endif

// ### logic/spfc_pkg.sv
// Types and shared decode functions of the flash controller
`default_nettype none
package spfc_pkg;
   // Sequencer states, Gray along idle, wait, commit
   typedef enum logic [1:0] {
      SPFC_IDLE = 2'b00,
      SPFC_WAIT = 2'b01,
      SPFC_COMMIT = 2'b11
   } spfc_state_t;

   // Unlock progress
   typedef enum logic [1:0] {
      SPFC_KEY_NONE = 2'b00,
      SPFC_KEY_HALF = 2'b01,
      SPFC_KEY_ARMED = 2'b11
   } spfc_key_t;

   // Register offset match
   function automatic logic spfc_hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : spfc_hit
endpackage : spfc_pkg
`default_nettype wire

// ### logic/spfc_arr_if.sv
// Link between the sequencer and the latch and flash array
`timescale 1ns/1ns
`default_nettype none
interface spfc_arr_if #(parameter int AW = 12, parameter int LW = 5);
   logic [AW-1:0] rd_addr;
   logic [23:0] rd_data;
   logic lat_we;
   logic [LW-1:0] lat_idx;
   logic [23:0] lat_wdata;
   logic [2:0] lat_be;
   logic com_we;
   logic com_erase;
   logic [AW-1:0] com_addr;
   modport ctl (output rd_addr, lat_we, lat_idx, lat_wdata, lat_be,
      com_we, com_erase, com_addr, input rd_data);
   modport arr (input rd_addr, lat_we, lat_idx, lat_wdata, lat_be,
      com_we, com_erase, com_addr, output rd_data);
endinterface : spfc_arr_if
`default_nettype wire

// ### logic/spfc_array.sv
// Panel write latches and program flash array of one panel
`timescale 1ns/1ns
`default_nettype none
`include "spfc_params.svh"
module spfc_array
   import spfc_pkg::*;
#(
   parameter int ROW_WORDS = `SPFC_ROW_WORDS,
   parameter int ROWS = `SPFC_PANEL_ROWS
) (
   input wire logic pclk,
   spfc_arr_if.arr port
);
   localparam int WORDS = ROW_WORDS * ROWS;
   localparam int LIW = $clog2(ROW_WORDS);

   // Shape check
   if (ROW_WORDS != 32 || ROWS < 1)
      begin : bad_shape
      $error("spfc_array: row must hold 32 words");
   end

   logic [23:0] flash_mem [0:WORDS-1];
   wire [23:0] latch_word;
   wire [LIW-1:0] com_idx = port.com_addr[LIW-1:0];

   // Table reads see the array word directly
   assign port.rd_data = flash_mem[port.rd_addr];

   // Latch byte lanes; each lane owns its store so one process writes it
   for (genvar b = 0; b < 3; b++) begin : g_lane
      logic [7:0] lane_mem [0:ROW_WORDS-1];
      always_ff @(posedge pclk) begin
         if (port.lat_we && port.lat_be[b]) begin
            lane_mem[port.lat_idx] <= port.lat_wdata[8*b +: 8];
         end
      end
      assign latch_word[8*b +: 8] = lane_mem[com_idx];
   end

   // Commit one row word per cycle: erased value or latched data
   always_ff @(posedge pclk) begin
      if (port.com_we) begin
         flash_mem[port.com_addr] <= port.com_erase ? `SPFC_ERASED_WORD :
            latch_word;
      end
   end
endmodule : spfc_array
`default_nettype wire

// ### tb/spfc_cpu_model.sv
// Processor-side model: APB master issuing register and table accesses
`timescale 1ns/1ns
`default_nettype none
module spfc_cpu_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end

   // One transfer: setup, access held until pready, then release
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer and data are taken at the rising edge that sees pready
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Released data does not keep its last value
   endtask : xfer

   // Two back-to-back key writes arm the next start
   task automatic unlock();
      logic [31:0] q;
      logic e;
      xfer(1'b1, 8'h0c, 32'h0000_0055, q, e);
      xfer(1'b1, 8'h0c, 32'h0000_00aa, q, e);
   endtask : unlock
endmodule : spfc_cpu_model
`default_nettype wire

// ### tb/spfc_top_bench.sv
// Self-checking bench for the flash controller register front end
`timescale 1ns/1ns
`default_nettype none
module spfc_top_bench;
   localparam int OPC = 20;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cpu_stall;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int t0;
   logic [23:0] img [0:31];
   logic [23:0] want;

   // Free-running cycle count for timing checks
   always @(posedge pclk) begin
      cyc <= cyc + 1;
   end

   spfc_top #(.OP_CYCLES(OPC)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_stall(cpu_stall));
   spfc_cpu_model cpu_u (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Clock, 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Report and end the run
   task automatic conclude();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   // Value compare
   task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu_u.xfer(1'b1, a, d, rd, er);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
      input string nm);
      cpu_u.xfer(1'b0, a, 32'h0000_0000, rd, er);
      chk(nm, exp, rd);
   endtask : rd_chk

   // Write control, count held cycles, then check start bit cleared
   task automatic run(input logic [31:0] c, input logic busy);
      int n;
      logic ok;
      n = 0;
      wr(8'h00, c);
      repeat (200) begin
         @(negedge pclk);
         if (cpu_stall === 1'b1)
            n++;
      end
      ok = busy ? (n >= OPC + 32 && n <= OPC + 33) : (n == 0);
      chk("stall span ok", 32'd1, {31'd0, ok});
      rd_chk(8'h00, c & 32'h0000_7fff, "ctrl after start");
   endtask : run

   // Program pattern per latch word
   function automatic logic [15:0] lo_of(input int i);
      return 16'ha5c3 ^ {i[7:0], i[7:0]};
   endfunction : lo_of

   // Expected row image after the one-word change
   function automatic logic [23:0] img_of(input int i);
      if (i == 5) begin
         return 24'h775a5a;
      end
      return {8'h10 + i[7:0], lo_of(i)};
   endfunction : img_of

   // Hang guard, far beyond the expected run
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      $display("[FAIL] watchdog expected finish seen timeout");
      conclude();
   end

   // Main sequence
   initial begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(8'h00, 32'h0, "ctrl reset");
      rd_chk(8'h04, 32'h0, "addr low reset");
      rd_chk(8'h08, 32'h0, "addr high reset");
      rd_chk(8'h10, 32'h0, "page reset");
      rd_chk(8'h14, 32'h0, "table addr reset");
      wr(8'h0c, 32'h0000_0055);
      rd_chk(8'h0c, 32'h0, "key read");
      cpu_u.xfer(1'b0, 8'h20, 32'h0, rd, er);
      chk("unmapped error", 32'd1, {31'd0, er});
      wr(8'h04, 32'h0000_1234);
      rd_chk(8'h04, 32'h0000_1234, "addr low direct");
      wr(8'h08, 32'h0000_0056);
      rd_chk(8'h08, 32'h0000_0056, "addr high direct");
      // Starts that must be ignored
      run(32'h0000_c041, 1'b0);
      cpu_u.unlock();
      run(32'h0000_8041, 1'b0);
      wr(8'h0c, 32'h0000_0055);
      wr(8'h04, 32'h0000_0040);
      wr(8'h0c, 32'h0000_00aa);
      run(32'h0000_c041, 1'b0);
      // Erase row 1
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h0000_0040);
      cpu_u.unlock();
      run(32'h0000_c041, 1'b1);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h0000_0040);
      wr(8'h18, 32'h0000_1357);
      rd_chk(8'h18, 32'h0000_ffff, "latch only");
      // Fill latches ascending from word 0, then program
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h0000_0040 + 2 * i);
         wr(8'h18, {16'h0, lo_of(i)});
         wr(8'h1c, 32'h0000_0010 + i);
      end
      cpu_u.unlock();
      run(32'h0000_c001, 1'b1);
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h0000_0040 + 2 * i);
         rd_chk(8'h18, {16'h0, lo_of(i)}, "word low");
         rd_chk(8'h1c, 32'h0000_0010 + i, "word high");
      end
      // Page plus table address, captured into address registers
      wr(8'h10, 32'h0000_003c);
      wr(8'h14, 32'h0000_0042);
      rd_chk(8'h18, {16'h0, lo_of(1)}, "paged read");
      rd_chk(8'h04, 32'h0000_0042, "addr low capture");
      rd_chk(8'h08, 32'h0000_003c, "addr high capture");
      // Row rewrite: read an image, change one word, erase, program back
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h0000_0040 + 2 * i);
         cpu_u.xfer(1'b0, 8'h18, 32'h0, rd, er);
         img[i][15:0] = rd[15:0];
         cpu_u.xfer(1'b0, 8'h1c, 32'h0, rd, er);
         img[i][23:16] = rd[7:0];
      end
      img[5] = 24'h775a5a;
      cpu_u.unlock();
      run(32'h0000_c041, 1'b1);
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h0000_0040 + 2 * i);
         wr(8'h18, {16'h0, img[i][15:0]});
         wr(8'h1c, {24'h0, img[i][23:16]});
      end
      cpu_u.unlock();
      wr(8'h00, 32'h0000_c001);
      t0 = cyc;
      // A read issued at once must wait out the whole operation
      rd_chk(8'h00, 32'h0000_4001, "ctrl after stall");
      chk("bus wait", 32'd1, {31'd0, cyc - t0 >= OPC + 32});
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h0000_0040 + 2 * i);
         want = img_of(i);
         rd_chk(8'h18, {16'h0, want[15:0]}, "img lo");
         rd_chk(8'h1c, {24'h0, want[23:16]}, "img hi");
      end
      // Erase the programmed row again
      cpu_u.unlock();
      run(32'h0000_c041, 1'b1);
      wr(8'h14, 32'h0000_007e);
      rd_chk(8'h18, 32'h0000_ffff, "row end erased");
      rd_chk(8'h1c, 32'h0000_00ff, "row end high");
      conclude();
   end
endmodule : spfc_top_bench
`default_nettype wire
